// *** pkg/scdg_defs.svh ***
// Offsets, field positions, reset values and timing counts of the clock block.
// Assumes a 10 MHz source clock and a 16-bit register port.
`ifndef SCDG_DEFS_SVH
`define SCDG_DEFS_SVH

// Register addresses as seen on the register port.
`define SCDG_ADDR_BUS_CFG   32'h0500_0000
`define SCDG_ADDR_TRIM      32'h0500_0002
`define SCDG_ADDR_PER_CFG   32'h0500_0004

// Bus clock register fields.
`define SCDG_OTP_GATE_BIT   7
`define SCDG_PCLK_DIV_LSB   4
`define SCDG_HCLK_DIV_LSB   0

// Crystal trim register fields.
`define SCDG_COARSE_LSB     8
`define SCDG_FINE_LSB       0

// Peripheral clock register fields.
`define SCDG_QUAD_GATE_BIT  15
`define SCDG_SPI_GATE_BIT   11
`define SCDG_SPI_DIV_LSB    8
`define SCDG_UART1_GATE_BIT 7
`define SCDG_UART2_GATE_BIT 6
`define SCDG_TWI_GATE_BIT   5
`define SCDG_WAKE_GATE_BIT  4
`define SCDG_TMR_GATE_BIT   3
`define SCDG_TIMER_DIV_LSB  0

// Reset values and writable bit masks; reserved bits read zero.
`define SCDG_RST_BUS_CFG    16'h0022
`define SCDG_MASK_BUS_CFG   16'h00b3
`define SCDG_RST_TRIM       16'h0000
`define SCDG_MASK_TRIM      16'h07ff
`define SCDG_RST_PER_CFG    16'h0000
`define SCDG_MASK_PER_CFG   16'h8bfb

// Divider codes after reset.
`define SCDG_RST_HCLK_CODE  2'h2
`define SCDG_RST_PCLK_CODE  2'h2

// Oscillator settling time after a coarse trim step.
`define SCDG_CLK_MHZ        10
`define SCDG_SETTLE_US      200
`define SCDG_SETTLE_CYC     (`SCDG_SETTLE_US * `SCDG_CLK_MHZ)

`endif

// *** pkg/scdg_pkg.sv ***
// Types shared by the clock divider and gating block.
// Assumes nothing beyond a SystemVerilog elaborator.
package scdg_pkg;

	// Bus clock configuration as decoded from its register.
	typedef struct packed {
		logic       otpGate;
		logic [1:0] pclkDiv;
		logic [1:0] hclkDiv;
	} scdg_bus_cfg_t;

	// Crystal trim codes.
	typedef struct packed {
		logic [2:0] coarse;
		logic [7:0] fine;
	} scdg_trim_t;

	// Peripheral clock configuration.
	typedef struct packed {
		logic       quadGate;
		logic       spiGate;
		logic [1:0] spiDiv;
		logic       uart1Gate;
		logic       uart2Gate;
		logic       twoWireGate;
		logic       wakeGate;
		logic       timerGate;
		logic [1:0] timerDiv;
	} scdg_per_cfg_t;

	// One-cycle clock enable pulses, one per derived clock.
	typedef struct packed {
		logic hclk;
		logic pclk;
		logic otp;
		logic quad;
		logic spi;
		logic uart1;
		logic uart2;
		logic twoWire;
		logic wake;
		logic timerZero;
		logic timerTwo;
	} scdg_ticks_t;

	// Last count of a power-of-two divider: code n divides by 2**n.
	function automatic logic [2:0] div_last(input logic [1:0] code);
		logic [3:0] ratio;
		ratio = 4'h1 << code;
		return 3'(ratio - 4'h1);
	endfunction

endpackage

// *** rtl/scdg_clk_div.sv ***
// Power-of-two clock enable divider with a glitch-free gate.
// Assumes srcTick is a one-cycle enable pulse on sys_clk.
`timescale 1ns/1ps

module scdg_clk_div #(
	parameter int                   CODE_W   = 2,
	parameter logic [CODE_W-1:0]    RST_CODE = '0,
	parameter logic                 RST_GATE = 1'b0
) (
	input  wire logic               sys_clk,
	input  wire logic               sys_rst,
	input  wire logic               srcTick,
	input  wire logic [CODE_W-1:0]  ratio,
	input  wire logic               gate,
	output logic                    tick,
	output logic [CODE_W-1:0]       code,
	output logic                    gateOn
);
	generate
		if (CODE_W != 2) begin : g_bad_width
			$error("scdg_clk_div serves a two-bit ratio code only.");
		end
	endgenerate

	logic [2:0]        cnt_q;
	logic [CODE_W-1:0] code_q;
	logic              gate_q;
	logic              tick_q;
	wire  logic        wrap;

	// A period ends on the source tick that reaches the last count.
	assign wrap   = srcTick && (cnt_q == scdg_pkg::div_last(code_q));
	assign tick   = tick_q;
	assign code   = code_q;
	assign gateOn = gate_q;

	// Ratio and gate are taken only at a period boundary, so no output
	// period is ever cut short by a register write.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cnt_q  <= 3'h0;
			code_q <= RST_CODE;
			gate_q <= RST_GATE;
			tick_q <= 1'b0;
		end else begin
			tick_q <= wrap && gate_q;
			if (srcTick) begin
				cnt_q <= wrap ? 3'h0 : cnt_q + 3'h1;
			end
			if (wrap) begin
				code_q <= ratio;
				gate_q <= gate;
			end
		end
	end
endmodule

// *** rtl/scdg_regs.sv ***
// Register file of the clock block: three 16-bit registers.
// Assumes single-cycle strobes; read data appear the cycle after rdStb.
`timescale 1ns/1ps
`include "scdg_defs.svh"

module scdg_regs (
	input  wire logic                   sys_clk,
	input  wire logic                   sys_rst,
	input  wire logic [31:0]            addr,
	input  wire logic [15:0]            wrData,
	input  wire logic                   wrStb,
	input  wire logic                   rdStb,
	output logic [15:0]                 rdData,
	output scdg_pkg::scdg_bus_cfg_t     busCfg,
	output scdg_pkg::scdg_trim_t        trim,
	output scdg_pkg::scdg_per_cfg_t     perCfg,
	output logic                        coarseStep
);
	logic [15:0] bus_q;
	logic [15:0] trim_q;
	logic [15:0] per_q;
	logic [15:0] rdData_q;
	wire  logic  selBus;
	wire  logic  selTrim;
	wire  logic  selPer;
	wire  logic [15:0] rdMux;

	// Address decode; unmapped addresses read zero and ignore writes.
	assign selBus  = (addr == `SCDG_ADDR_BUS_CFG);
	assign selTrim = (addr == `SCDG_ADDR_TRIM);
	assign selPer  = (addr == `SCDG_ADDR_PER_CFG);
	assign rdMux   = selBus ? bus_q : selTrim ? trim_q :
		selPer ? per_q : 16'h0000;
	assign rdData  = rdData_q;

	// A coarse step is a trim write that changes the coarse code.
	assign coarseStep = wrStb && selTrim &&
		(wrData[`SCDG_COARSE_LSB +: 3] != trim_q[`SCDG_COARSE_LSB +: 3]);

	// Field views handed to the dividers and the trim outputs.
	assign busCfg.otpGate     = bus_q[`SCDG_OTP_GATE_BIT];
	assign busCfg.pclkDiv     = bus_q[`SCDG_PCLK_DIV_LSB +: 2];
	assign busCfg.hclkDiv     = bus_q[`SCDG_HCLK_DIV_LSB +: 2];
	assign trim.coarse        = trim_q[`SCDG_COARSE_LSB +: 3];
	assign trim.fine          = trim_q[`SCDG_FINE_LSB +: 8];
	assign perCfg.quadGate    = per_q[`SCDG_QUAD_GATE_BIT];
	assign perCfg.spiGate     = per_q[`SCDG_SPI_GATE_BIT];
	assign perCfg.spiDiv      = per_q[`SCDG_SPI_DIV_LSB +: 2];
	assign perCfg.uart1Gate   = per_q[`SCDG_UART1_GATE_BIT];
	assign perCfg.uart2Gate   = per_q[`SCDG_UART2_GATE_BIT];
	assign perCfg.twoWireGate = per_q[`SCDG_TWI_GATE_BIT];
	assign perCfg.wakeGate    = per_q[`SCDG_WAKE_GATE_BIT];
	assign perCfg.timerGate   = per_q[`SCDG_TMR_GATE_BIT];
	assign perCfg.timerDiv    = per_q[`SCDG_TIMER_DIV_LSB +: 2];

	// Reserved bits are masked on write so they always read zero.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			bus_q    <= `SCDG_RST_BUS_CFG;
			trim_q   <= `SCDG_RST_TRIM;
			per_q    <= `SCDG_RST_PER_CFG;
			rdData_q <= 16'h0000;
		end else begin
			rdData_q <= rdStb ? rdMux : 16'h0000;
			if (wrStb && selBus) begin
				bus_q <= wrData & `SCDG_MASK_BUS_CFG;
			end
			if (wrStb && selTrim) begin
				trim_q <= wrData & `SCDG_MASK_TRIM;
			end
			if (wrStb && selPer) begin
				per_q <= wrData & `SCDG_MASK_PER_CFG;
			end
		end
	end
endmodule

// *** rtl/scdg_top.sv ***
// Clock divider and gating block: bus, peripheral bus and peripheral
// clock enables derived from the source clock, plus crystal trim codes.
// Assumes sys_clk is the selected source clock and downstream logic
// clocks on sys_clk qualified by the tick pulses below.
`timescale 1ns/1ps
`include "scdg_defs.svh"

module scdg_top (
	input  wire logic                 sys_clk,
	input  wire logic                 sys_rst,
	input  wire logic [31:0]          addr,
	input  wire logic [15:0]          wrData,
	input  wire logic                 wrStb,
	input  wire logic                 rdStb,
	output logic [15:0]               rdData,
	output scdg_pkg::scdg_ticks_t     clkTicks,
	output logic [2:0]                xtalTrimCoarse,
	output logic [7:0]                xtalTrimFine,
	output logic                      trimSettling
);
	localparam logic [11:0] SETTLE_CYC = 12'(`SCDG_SETTLE_CYC);

	scdg_pkg::scdg_bus_cfg_t busCfg;
	scdg_pkg::scdg_trim_t    trim;
	scdg_pkg::scdg_per_cfg_t perCfg;
	logic                    coarseStep;
	logic [1:0]              hclkCode;
	logic [1:0]              pclkCode;
	logic [1:0]              spiCode;
	logic [1:0]              timerCode;
	logic                    otpGateOn;
	logic                    quadGateOn;
	logic                    spiGateOn;
	logic                    timerGateOn;
	logic [11:0]             settle_q;
	logic [11:0]             settle_d;

	// Register port and field decode.
	scdg_regs u_regs (
		.sys_clk    (sys_clk),
		.sys_rst    (sys_rst),
		.addr       (addr),
		.wrData     (wrData),
		.wrStb      (wrStb),
		.rdStb      (rdStb),
		.rdData     (rdData),
		.busCfg     (busCfg),
		.trim       (trim),
		.perCfg     (perCfg),
		.coarseStep (coarseStep)
	);

	// Trim codes go straight from their register to the oscillator.
	assign xtalTrimCoarse = trim.coarse;
	assign xtalTrimFine   = trim.fine;

	// Bus and processor clock, divided from the source clock.
	scdg_clk_div #(.RST_CODE(`SCDG_RST_HCLK_CODE), .RST_GATE(1'b1)) u_hclk (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.srcTick (1'b1),
		.ratio   (busCfg.hclkDiv),
		.gate    (1'b1),
		.tick    (clkTicks.hclk),
		.code    (hclkCode),
		.gateOn  ()
	);

	// Peripheral bus clock is cascaded behind the bus clock, so its
	// effective ratio is the product of both divide ratios.
	scdg_clk_div #(.RST_CODE(`SCDG_RST_PCLK_CODE), .RST_GATE(1'b1)) u_pclk (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.srcTick (clkTicks.hclk),
		.ratio   (busCfg.pclkDiv),
		.gate    (1'b1),
		.tick    (clkTicks.pclk),
		.code    (pclkCode),
		.gateOn  ()
	);

	// Memory controller clock: the bus clock behind its gate.
	scdg_clk_div u_otp (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.srcTick (clkTicks.hclk),
		.ratio   (2'h0),
		.gate    (busCfg.otpGate),
		.tick    (clkTicks.otp),
		.code    (),
		.gateOn  (otpGateOn)
	);

	// Quadrature decoder clock.
	scdg_clk_div u_quad (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.srcTick (1'b1),
		.ratio   (2'h0),
		.gate    (perCfg.quadGate),
		.tick    (clkTicks.quad),
		.code    (),
		.gateOn  (quadGateOn)
	);

	// Serial peripheral interface clock, gated and divided.
	scdg_clk_div u_spi (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.srcTick (1'b1),
		.ratio   (perCfg.spiDiv),
		.gate    (perCfg.spiGate),
		.tick    (clkTicks.spi),
		.code    (spiCode),
		.gateOn  (spiGateOn)
	);

	// First and second serial ports.
	scdg_clk_div u_uart1 (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.srcTick (1'b1),
		.ratio   (2'h0),
		.gate    (perCfg.uart1Gate),
		.tick    (clkTicks.uart1),
		.code    (),
		.gateOn  ()
	);
	scdg_clk_div u_uart2 (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.srcTick (1'b1),
		.ratio   (2'h0),
		.gate    (perCfg.uart2Gate),
		.tick    (clkTicks.uart2),
		.code    (),
		.gateOn  ()
	);

	// Two-wire bus and wake-up capture timer.
	scdg_clk_div u_twi (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.srcTick (1'b1),
		.ratio   (2'h0),
		.gate    (perCfg.twoWireGate),
		.tick    (clkTicks.twoWire),
		.code    (),
		.gateOn  ()
	);
	scdg_clk_div u_wake (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.srcTick (1'b1),
		.ratio   (2'h0),
		.gate    (perCfg.wakeGate),
		.tick    (clkTicks.wake),
		.code    (),
		.gateOn  ()
	);

	// Both timers share one gate; only timer zero has a divider.
	scdg_clk_div u_timer_zero (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.srcTick (1'b1),
		.ratio   (perCfg.timerDiv),
		.gate    (perCfg.timerGate),
		.tick    (clkTicks.timerZero),
		.code    (timerCode),
		.gateOn  (timerGateOn)
	);
	scdg_clk_div u_timer_two (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.srcTick (1'b1),
		.ratio   (2'h0),
		.gate    (perCfg.timerGate),
		.tick    (clkTicks.timerTwo),
		.code    (),
		.gateOn  ()
	);

	// Settling indicator: the block does not block a second step, it only
	// shows software when the oscillator has had its settling time.
	assign settle_d = coarseStep ? SETTLE_CYC :
		(settle_q != 12'h000) ? settle_q - 12'h001 : 12'h000;
	assign trimSettling = (settle_q != 12'h000);
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			settle_q <= 12'h000;
		end else begin
			settle_q <= settle_d;
		end
	end

	// Checks below look at the tick lines as a consumer sees them. A tick
	// always carries the code of the period that it opens, not the old one.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	a_hclk_div_four: assert property (
		clkTicks.hclk && hclkCode == 2'h2 && $stable(hclkCode)
		|=> !clkTicks.hclk [*3] ##1 clkTicks.hclk)
		else $error("Bus clock period at divide by four is wrong.");

	a_hclk_div_eight: assert property (
		clkTicks.hclk && hclkCode == 2'h3 && busCfg.hclkDiv == 2'h3
		|=> !clkTicks.hclk [*7] ##1 clkTicks.hclk)
		else $error("Bus clock period at divide by eight is wrong.");

	a_pclk_after_hclk: assert property (
		clkTicks.pclk |-> $past(clkTicks.hclk))
		else $error("Peripheral bus tick without a bus tick before it.");

	a_otp_gate_off: assert property (
		!otpGateOn |=> !clkTicks.otp)
		else $error("Memory controller clock ran while gated off.");

	a_otp_gate_on: assert property (
		otpGateOn && clkTicks.hclk |=> clkTicks.otp)
		else $error("Memory controller clock missed a bus clock tick.");

	a_otp_after_hclk: assert property (
		clkTicks.otp |-> $past(clkTicks.hclk))
		else $error("Memory controller tick without a bus tick before it.");

	a_trim_write: assert property (
		wrStb && addr == `SCDG_ADDR_TRIM
		|=> xtalTrimCoarse == $past(wrData[10:8])
			&& xtalTrimFine == $past(wrData[7:0]))
		else $error("Trim codes did not follow the trim write.");

	a_trim_hold: assert property (
		!(wrStb && addr == `SCDG_ADDR_TRIM)
		|=> $stable(xtalTrimCoarse) && $stable(xtalTrimFine))
		else $error("Trim codes changed without a trim write.");

	a_quad_gate_off: assert property (
		!quadGateOn |=> !clkTicks.quad)
		else $error("Quadrature clock ran while gated off.");

	a_quad_gate_on: assert property (
		quadGateOn |=> clkTicks.quad)
		else $error("Quadrature clock missed a cycle while gated on.");

	a_spi_div_two: assert property (
		clkTicks.spi && spiCode == 2'h1 && perCfg.spiDiv == 2'h1
		&& spiGateOn |=> !clkTicks.spi ##1 clkTicks.spi)
		else $error("Serial interface clock not divided by two.");

	a_spi_code_edge: assert property (
		$changed(spiCode) |-> clkTicks.spi || !$past(spiGateOn))
		else $error("Serial interface ratio changed inside a period.");

	a_gates_reset_off: assert property (
		$fell(sys_rst) |-> !clkTicks.uart1 && !clkTicks.uart2
			&& !clkTicks.twoWire && !clkTicks.wake)
		else $error("Serial or wake clock active right after reset.");

	a_timers_together: assert property (
		timerCode == 2'h0 && $stable(timerCode)
		|-> clkTicks.timerZero == clkTicks.timerTwo)
		else $error("Timer clocks not gated together.");

	a_timer_two_gate: assert property (
		!$past(perCfg.timerGate) |=> !clkTicks.timerTwo)
		else $error("Timer two clock ran while gated off.");

	a_timer_div_four: assert property (
		clkTicks.timerZero && timerCode == 2'h2 && perCfg.timerDiv == 2'h2
		&& timerGateOn && perCfg.timerGate
		|=> !clkTicks.timerZero [*3] ##1 clkTicks.timerZero)
		else $error("Timer zero not divided by four.");

	a_timer_code_edge: assert property (
		$changed(timerCode) |-> clkTicks.timerZero || !$past(timerGateOn))
		else $error("Timer zero ratio changed inside a period.");

	a_ratio_at_boundary: assert property (
		$changed(hclkCode) |-> clkTicks.hclk)
		else $error("Bus clock ratio changed inside a clock period.");

	a_pclk_code_edge: assert property (
		$changed(pclkCode) |-> clkTicks.pclk)
		else $error("Peripheral bus ratio changed inside a period.");

	a_settle_window: assert property (
		coarseStep |=> trimSettling [*8])
		else $error("Settling indicator did not hold after a step.");
endmodule

// *** test/scdg_tick_monitor.sv ***
// Downstream clock consumer model: measures the spacing of every tick line.
// Assumes the tick struct of the clock block, sampled on sys_clk.
`timescale 1ns/1ps

module scdg_tick_monitor (
	input  wire logic                  sys_clk,
	input  wire logic                  sys_rst,
	input  wire logic                  clrMin,
	input  wire scdg_pkg::scdg_ticks_t clkTicks,
	output logic [10:0][7:0]           gap,
	output logic [10:0][7:0]           minGap,
	output logic [10:0][7:0]           age
);
	logic [10:0] tk;

	assign tk = clkTicks;

	// Ages saturate, so a stopped clock reads as a large and stable value.
	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < 11; i++) begin
			if (sys_rst || clrMin) begin
				minGap[i] <= 8'hff;
			end else if (tk[i] && age[i] < minGap[i]) begin
				minGap[i] <= age[i] + 8'h01;
			end
			if (sys_rst) begin
				age[i] <= 8'h00;
				gap[i] <= 8'h00;
			end else if (tk[i]) begin
				age[i] <= 8'h00;
				gap[i] <= (age[i] == 8'hff) ? age[i] : age[i] + 8'h01;
			end else if (age[i] != 8'hff) begin
				age[i] <= age[i] + 8'h01;
			end
		end
	end
endmodule

// *** test/scdg_top_tb.sv ***
// Self-checking bench of the clock block: register port tasks and tick
// spacing checks. Assumes the tick monitor model beside the design.
`timescale 1ns/1ps
`include "scdg_defs.svh"

`define CHK(what, expv, gotv) \
	begin \
		nCompared++; \
		if ((gotv) !== (expv)) begin \
			miscompares++; \
			$display("CHECK FAILED %s exp %0h got %0h", what, expv, gotv); \
		end \
	end

module scdg_top_tb;
	localparam int HCLK = 10;
	localparam int PCLK = 9;
	localparam int OTP  = 8;
	localparam int SPI  = 6;
	localparam int TMR0 = 1;
	localparam int GB[7] = '{15, 11, 7, 6, 5, 4, 3};

	logic                  sys_clk = 1'b0;
	logic                  sys_rst;
	logic [31:0]           addr;
	logic [15:0]           wrData;
	logic                  wrStb;
	logic                  rdStb;
	logic                  clrMin;
	logic                  expOn;
	logic [15:0]           rdData;
	scdg_pkg::scdg_ticks_t clkTicks;
	logic [2:0]            xtalTrimCoarse;
	logic [7:0]            xtalTrimFine;
	logic                  trimSettling;
	logic [10:0][7:0]      gap;
	logic [10:0][7:0]      minGap;
	logic [10:0][7:0]      age;
	int                    miscompares = 0;
	int                    nCompared = 0;

	// Source clock of 100 ns period.
	always #50 sys_clk = ~sys_clk;

	scdg_top uut (
		.sys_clk        (sys_clk),
		.sys_rst        (sys_rst),
		.addr           (addr),
		.wrData         (wrData),
		.wrStb          (wrStb),
		.rdStb          (rdStb),
		.rdData         (rdData),
		.clkTicks       (clkTicks),
		.xtalTrimCoarse (xtalTrimCoarse),
		.xtalTrimFine   (xtalTrimFine),
		.trimSettling   (trimSettling)
	);

	scdg_tick_monitor mon (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.clrMin   (clrMin),
		.clkTicks (clkTicks),
		.gap      (gap),
		.minGap   (minGap),
		.age      (age)
	);

	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop();
		$display("Compared %0d, mismatched %0d", nCompared, miscompares);
		if (miscompares == 0 && nCompared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// One-cycle write strobe.
	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		addr <= a;
		wrData <= d;
		wrStb <= 1'b1;
		@(posedge sys_clk);
		wrStb <= 1'b0;
	endtask

	// One-cycle read strobe; data stand only in the following cycle.
	task automatic rd(input logic [31:0] a, input logic [15:0] e,
		input string n);
		@(posedge sys_clk);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge sys_clk);
		rdStb <= 1'b0;
		#1;
		`CHK(n, e, rdData)
	endtask

	// Covers the longest switch delay plus one full new period.
	task automatic settle();
		repeat (160) @(posedge sys_clk);
		#1;
	endtask

	initial begin
		sys_rst = 1'b1;
		addr = 32'h0000_0000;
		wrData = 16'h0000;
		wrStb = 1'b0;
		rdStb = 1'b0;
		clrMin = 1'b0;
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(`SCDG_ADDR_BUS_CFG, `SCDG_RST_BUS_CFG, "bus");
		rd(`SCDG_ADDR_TRIM, 16'h0000, "trim");
		rd(`SCDG_ADDR_PER_CFG, 16'h0000, "per");
		rd(32'h0500_0006, 16'h0000, "unmapped");
		settle();
		`CHK("hclk rst", 8'd4, gap[HCLK])
		`CHK("pclk rst", 8'd16, gap[PCLK])
		`CHK("otp rst", 1'b1, age[OTP] > 8'd100)
		wr(`SCDG_ADDR_BUS_CFG, 16'hffff);
		rd(`SCDG_ADDR_BUS_CFG, `SCDG_MASK_BUS_CFG, "bus mask");
		wr(32'h0500_0006, 16'h0000);
		rd(`SCDG_ADDR_BUS_CFG, `SCDG_MASK_BUS_CFG, "unmapped wr");
		settle();
		`CHK("hclk 8", 8'd8, gap[HCLK])
		`CHK("pclk 64", 8'd64, gap[PCLK])
		`CHK("otp on", 8'd8, gap[OTP])
		// A switch to a faster ratio must not yield a short period.
		@(posedge sys_clk);
		clrMin <= 1'b1;
		@(posedge sys_clk);
		clrMin <= 1'b0;
		wr(`SCDG_ADDR_BUS_CFG, 16'h00b2);
		settle();
		`CHK("hclk min", 8'd4, minGap[HCLK])
		for (int c = 0; c < 4; c++) begin
			wr(`SCDG_ADDR_BUS_CFG, 16'(c));
			settle();
			`CHK("hclk div", 8'h01 << c, gap[HCLK])
			`CHK("pclk cascade", 8'h01 << c, gap[PCLK])
			`CHK("otp off", 1'b1, age[OTP] > 8'd100)
		end
		for (int p = 0; p < 4; p++) begin
			wr(`SCDG_ADDR_BUS_CFG, 16'h0081 | 16'(p << 4));
			settle();
			`CHK("pclk div", 8'h02 << p, gap[PCLK])
			`CHK("otp hclk", 8'd2, gap[OTP])
		end
		wr(`SCDG_ADDR_PER_CFG, 16'hffff);
		rd(`SCDG_ADDR_PER_CFG, `SCDG_MASK_PER_CFG, "per mask");
		for (int c = 0; c < 4; c++) begin
			wr(`SCDG_ADDR_PER_CFG, 16'h08f8 | 16'(c << 8) | 16'(c));
			settle();
			`CHK("spi div", 8'h01 << c, gap[SPI])
			`CHK("tmr0 div", 8'h01 << c, gap[TMR0])
			`CHK("tmr2 undiv", 8'd1, gap[0])
		end
		// Each gate alone; only its own line (timer two with timer zero) runs.
		for (int k = 0; k < 7; k++) begin
			wr(`SCDG_ADDR_PER_CFG, 16'h0001 << GB[k]);
			settle();
			for (int j = 0; j < 8; j++) begin
				expOn = (j == 7 - k) || (k == 6 && j == 0);
				`CHK("gate", expOn, age[j] == 8'h00)
			end
		end
		wr(`SCDG_ADDR_TRIM, 16'h00ff);
		rd(`SCDG_ADDR_TRIM, 16'h00ff, "fine max");
		`CHK("fine out", 8'hff, xtalTrimFine)
		wr(`SCDG_ADDR_TRIM, 16'h01a5);
		#1;
		`CHK("settle on", 1'b1, trimSettling)
		`CHK("coarse out", 3'h1, xtalTrimCoarse)
		`CHK("fine keep", 8'ha5, xtalTrimFine)
		repeat (1990) @(posedge sys_clk);
		#1;
		`CHK("settle held", 1'b1, trimSettling)
		repeat (20) @(posedge sys_clk);
		#1;
		`CHK("settle done", 1'b0, trimSettling)
		wr(`SCDG_ADDR_TRIM, 16'hfaa5);
		rd(`SCDG_ADDR_TRIM, 16'h02a5, "trim mask");
		report_and_stop();
	end

	// Watchdog, well beyond the roughly 6000 cycles the tests need.
	initial begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		report_and_stop();
	end
endmodule
